/* rtl/adc_acc_pkg.sv */
// Package holding the accumulator configuration layout, encodings and constants.
package adc_acc_pkg;

  // ==========================================================================
  // Register location and field layout
  // ==========================================================================
  localparam logic [7:0] ACC_CFG_ADDR = 8'hba;
  localparam logic [7:0] ACC_CFG_RESET = 8'h00;
  localparam int TWELVE_BIT_POS = 7;
  localparam int ACCUM_EN_POS = 6;
  localparam int SHIFT_SEL_MSB = 5;
  localparam int SHIFT_SEL_LSB = 3;
  localparam int REPEAT_MSB = 2;
  localparam int REPEAT_LSB = 0;

  // ==========================================================================
  // Shift and justify codes
  // ==========================================================================
  localparam logic [2:0] SJ_RIGHT_NONE = 3'h0;
  localparam logic [2:0] SJ_RIGHT_SH1 = 3'h1;
  localparam logic [2:0] SJ_RIGHT_SH2 = 3'h2;
  localparam logic [2:0] SJ_RIGHT_SH3 = 3'h3;
  localparam logic [2:0] SJ_LEFT_NONE = 3'h4;

  // Left shift that moves a 12-bit or 10-bit sample to the top of the word.
  localparam logic [3:0] LEFT_SHIFT_12 = 4'h4;
  localparam logic [3:0] LEFT_SHIFT_10 = 4'h6;

  // ==========================================================================
  // Repeat count codes and widths
  // ==========================================================================
  localparam logic [2:0] RPT_1 = 3'h0;
  localparam logic [2:0] RPT_4 = 3'h1;
  localparam logic [2:0] RPT_8 = 3'h2;
  localparam logic [2:0] RPT_16 = 3'h3;
  localparam logic [2:0] RPT_32 = 3'h4;
  localparam logic [2:0] RPT_64 = 3'h5;
  localparam int SAMPLE_W = 12;
  localparam int WORD_W = 16;
  localparam int COUNT_W = 7;

  // Burst sequencer states, one-hot.
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_REQ = 3'b010,
    ST_WAIT = 3'b100
  } burst_state_t;

endpackage

/* rtl/result_formatter.sv */
// Registered shift and justify stage that turns the accumulator into the readable result word.
`timescale 1ns/100ps

module result_formatter
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Accumulator and format selection
  input wire logic [15:0] i_acc,
  input wire logic [2:0] i_shift_sel,
  input wire logic i_twelve_bit,
  // Formatted word
  output logic [15:0] o_word
);

  // ==========================================================================
  // Format stage
  // ==========================================================================
  logic [15:0] nxt_word;

  // Reserved codes fall back to right justified with no shift so the word never goes stale.
  always_comb
  begin
    unique case (i_shift_sel)
      adc_acc_pkg::SJ_RIGHT_SH1: nxt_word = i_acc >> 1; // [R6]
      adc_acc_pkg::SJ_RIGHT_SH2: nxt_word = i_acc >> 2; // [R6]
      adc_acc_pkg::SJ_RIGHT_SH3: nxt_word = i_acc >> 3; // [R6]
      adc_acc_pkg::SJ_LEFT_NONE:
        nxt_word = i_acc << (i_twelve_bit ? adc_acc_pkg::LEFT_SHIFT_12 : adc_acc_pkg::LEFT_SHIFT_10); // [R6]
      default: nxt_word = i_acc; // [R6]
    endcase
  end

  // The output is registered so the result bus has a clean flop source.
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_word <= 16'h0000;
    end
    else
    begin
      o_word <= nxt_word;
    end
  end

endmodule

/* rtl/adc_accumulator_format.sv */
// Accumulator configuration register, conversion accumulator and burst sequencer of the converter.
// What this block does
// R1: When the twelve-bit enable bit is set the converter runs in 12-bit mode, otherwise not.
// R2: With burst off and accumulate enable clear, each conversion replaces the result word.
// R3: With burst off and accumulate enable set, each conversion is added into the result word.
// R4: Software restarts the sum by writing zero into both result bytes; outside a burst the block never clears it itself.
// R5: The accumulate enable bit is writable but always reads back as zero.
// R6: The shift/justify field selects right justify with shift 0 to 3, or left justify with no shift.
// R7: In burst mode the repeat field selects 1, 4, 8, 16, 32 or 64 conversions, all summed.
// R8: Software keeps the repeat field at zero while burst mode is off.
// R9: In burst mode with the converter enable clear, the converter powers down after the last conversion.
// R10: Reset clears the whole configuration register to zero.
`timescale 1ns/100ps

module adc_accumulator_format
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Special function register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // Result word byte writes from software
  input wire logic i_result_wr_hi,
  input wire logic i_result_wr_lo,
  input wire logic [7:0] i_result_wdata,
  // Converter control
  input wire logic i_burst_mode_enable,
  input wire logic i_converter_enable,
  input wire logic i_start,
  input wire logic i_conv_done,
  input wire logic [11:0] i_conv_data,
  // Converter controls and result
  output logic o_twelve_bit_mode,
  output logic o_conv_request,
  output logic o_converter_powered,
  output logic o_burst_busy,
  output logic o_burst_done,
  output logic [15:0] o_result_word
);

  // ==========================================================================
  // Configuration register
  // ==========================================================================
  logic twelve_bit_ff;
  logic accum_en_ff;
  logic [2:0] shift_sel_ff;
  logic [2:0] repeat_ff;
  logic cfg_sel;

  assign cfg_sel = (i_sfr_addr == adc_acc_pkg::ACC_CFG_ADDR);

  // Number of conversions in one burst for a repeat code; reserved codes act as one.
  function automatic logic [6:0] repeat_total(input logic [2:0] code);
    logic [6:0] total;
    total = 7'h01;
    unique case (code)
      adc_acc_pkg::RPT_4: total = 7'h04;
      adc_acc_pkg::RPT_8: total = 7'h08;
      adc_acc_pkg::RPT_16: total = 7'h10;
      adc_acc_pkg::RPT_32: total = 7'h20;
      adc_acc_pkg::RPT_64: total = 7'h40;
      default: total = 7'h01;
    endcase
    return total;
  endfunction

  // Every field clears on reset; a write replaces all fields at once.
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      twelve_bit_ff <= adc_acc_pkg::ACC_CFG_RESET[adc_acc_pkg::TWELVE_BIT_POS]; // [R10]
      accum_en_ff <= adc_acc_pkg::ACC_CFG_RESET[adc_acc_pkg::ACCUM_EN_POS]; // [R10]
      shift_sel_ff <= adc_acc_pkg::ACC_CFG_RESET[adc_acc_pkg::SHIFT_SEL_MSB:adc_acc_pkg::SHIFT_SEL_LSB]; // [R10]
      repeat_ff <= adc_acc_pkg::ACC_CFG_RESET[adc_acc_pkg::REPEAT_MSB:adc_acc_pkg::REPEAT_LSB]; // [R10]
    end
    else if (i_sfr_wr && cfg_sel)
    begin
      twelve_bit_ff <= i_sfr_wdata[adc_acc_pkg::TWELVE_BIT_POS]; // [R1]
      accum_en_ff <= i_sfr_wdata[adc_acc_pkg::ACCUM_EN_POS];
      shift_sel_ff <= i_sfr_wdata[adc_acc_pkg::SHIFT_SEL_MSB:adc_acc_pkg::SHIFT_SEL_LSB];
      repeat_ff <= i_sfr_wdata[adc_acc_pkg::REPEAT_MSB:adc_acc_pkg::REPEAT_LSB];
    end
  end

  // Read data is registered; other addresses and idle cycles read zero.
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_sfr_rdata <= 8'h00;
    end
    else if (i_sfr_rd && cfg_sel)
    begin
      o_sfr_rdata <= {twelve_bit_ff, 1'b0, shift_sel_ff, repeat_ff}; // [R5]
    end
    else
    begin
      o_sfr_rdata <= 8'h00;
    end
  end

  // The mode flag follows the register so the converter sees a flop output.
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_twelve_bit_mode <= 1'b0;
    end
    else
    begin
      o_twelve_bit_mode <= twelve_bit_ff; // [R1]
    end
  end

  // ==========================================================================
  // Burst sequencer
  // ==========================================================================
  adc_acc_pkg::burst_state_t state_ff;
  logic [6:0] done_cnt_ff;
  logic [6:0] target_ff;
  logic last_done;

  assign last_done = (state_ff == adc_acc_pkg::ST_WAIT) && i_conv_done && (done_cnt_ff + 7'h01 == target_ff);

  // One conversion is requested at a time, so a slow converter can never be overrun.
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_ff <= adc_acc_pkg::ST_IDLE;
      done_cnt_ff <= 7'h00;
      target_ff <= 7'h01;
    end
    else
    begin
      unique case (state_ff)
        adc_acc_pkg::ST_IDLE:
          if (i_start && i_burst_mode_enable)
          begin
            state_ff <= adc_acc_pkg::ST_REQ;
            done_cnt_ff <= 7'h00;
            target_ff <= repeat_total(repeat_ff); // [R7]
          end
        adc_acc_pkg::ST_REQ:
          state_ff <= adc_acc_pkg::ST_WAIT;
        adc_acc_pkg::ST_WAIT:
          if (i_conv_done)
          begin
            done_cnt_ff <= done_cnt_ff + 7'h01; // [R7]
            state_ff <= last_done ? adc_acc_pkg::ST_IDLE : adc_acc_pkg::ST_REQ; // [R7]
          end
        default:
          state_ff <= adc_acc_pkg::ST_IDLE;
      endcase
    end
  end

  // Request, busy, done and power outputs are all registered.
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_conv_request <= 1'b0;
      o_burst_busy <= 1'b0;
      o_burst_done <= 1'b0;
      o_converter_powered <= 1'b0;
    end
    else
    begin
      o_conv_request <= (state_ff == adc_acc_pkg::ST_REQ);
      o_burst_busy <= (state_ff != adc_acc_pkg::ST_IDLE) && !last_done;
      o_burst_done <= last_done;
      // Powered while enabled, or only until the burst's final conversion lands.
      o_converter_powered <= i_converter_enable || ((state_ff != adc_acc_pkg::ST_IDLE) && !last_done); // [R9]
    end
  end

  // ==========================================================================
  // Accumulator
  // ==========================================================================
  logic [15:0] acc_ff;
  logic [15:0] sample;
  logic burst_first;

  assign sample = {4'h0, i_conv_data};
  assign burst_first = (state_ff == adc_acc_pkg::ST_WAIT) && (done_cnt_ff == 7'h00);

  // A software byte write wins over a conversion landing in the same cycle.
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      acc_ff <= 16'h0000;
    end
    else if (i_result_wr_hi || i_result_wr_lo)
    begin
      if (i_result_wr_hi)
      begin
        acc_ff[15:8] <= i_result_wdata; // [R4]
      end
      if (i_result_wr_lo)
      begin
        acc_ff[7:0] <= i_result_wdata; // [R4]
      end
    end
    else if (i_conv_done)
    begin
      if (state_ff != adc_acc_pkg::ST_IDLE)
      begin
        acc_ff <= burst_first ? sample : acc_ff + sample; // [R7]
      end
      else if (accum_en_ff)
      begin
        acc_ff <= acc_ff + sample; // [R3]
      end
      else
      begin
        acc_ff <= sample; // [R2]
      end
    end
  end

  result_formatter u_fmt
  (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_acc(acc_ff),
    .i_shift_sel(shift_sel_ff),
    .i_twelve_bit(twelve_bit_ff),
    .o_word(o_result_word)
  );

endmodule

/* sim/adc_accumulator_format_asserts.sv */
// Concurrent checks on the ports of the accumulator configuration block.
`timescale 1ns/100ps

module adc_accumulator_format_chk
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  // Converter control
  input wire logic i_start,
  input wire logic i_burst_mode_enable,
  input wire logic i_converter_enable,
  input wire logic o_twelve_bit_mode,
  input wire logic o_conv_request,
  input wire logic o_converter_powered,
  input wire logic o_burst_busy,
  input wire logic o_burst_done
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // A configuration write in this cycle.
  wire logic cfg_wr = i_sfr_wr && (i_sfr_addr == adc_acc_pkg::ACC_CFG_ADDR);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // Read data is only non-zero right after a read, and bit 6 never shows.
  a_rdata_idle: assert property (!$past(i_sfr_rd) |-> o_sfr_rdata == 8'h00) else $error("read data not idle");
  a_accum_hidden: assert property (o_sfr_rdata[6] == 1'b0) else $error("accumulate bit visible");
  a_cfg_readback: assert property (cfg_wr ##1 (i_sfr_rd && !cfg_wr && i_sfr_addr == 8'hba) |=>
    o_sfr_rdata == ($past(i_sfr_wdata, 2) & 8'hbf)) else $error("readback differs from write");
  // The mode output follows bit 7 two cycles after the write.
  a_twelve_follows: assert property (cfg_wr ##1 !cfg_wr |=> o_twelve_bit_mode == $past(i_sfr_wdata[7], 2))
    else $error("twelve bit mode wrong");
  // A start while idle asks for the first conversion two cycles later, as one pulse.
  // A start right after another start may land while the sequencer has just left idle, so it is left out.
  a_start_request: assert property (i_start && i_burst_mode_enable && !$past(i_start) && !o_burst_busy
    && !o_burst_done |-> ##2 o_conv_request) else $error("no request after start");
  a_request_pulse: assert property (o_conv_request |=> !o_conv_request) else $error("request longer than a cycle");
  // Power follows the enable once the burst has ended, and stays up while it runs.
  a_done_power: assert property (o_burst_done |-> !o_burst_busy && o_converter_powered == $past(i_converter_enable))
    else $error("power state wrong after burst");
  a_busy_powered: assert property (o_burst_busy |-> o_converter_powered) else $error("burst without power");
  a_reset_clears: assert property ($fell(i_reset) |-> !o_twelve_bit_mode && !o_burst_busy && o_sfr_rdata == 8'h00)
    else $error("outputs not clear after reset");

  // Main scenarios seen.
  c_burst_done: cover property (o_burst_done);
  c_cfg_read: cover property (cfg_wr ##1 i_sfr_rd);
  c_request: cover property (o_conv_request);
endmodule

bind adc_accumulator_format adc_accumulator_format_chk u_chk (.i_mclk, .i_reset, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
  .i_sfr_wdata, .o_sfr_rdata, .i_start, .i_burst_mode_enable, .i_converter_enable, .o_twelve_bit_mode, .o_conv_request,
  .o_converter_powered, .o_burst_busy, .o_burst_done);

/* sim/adc_accumulator_format_tb.sv */
// Self-checking testbench for the accumulator configuration and result formatting block.
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t got %h want %h", $time, a, e); end end

module adc_accumulator_format_tb;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_result_wr_hi = 1'b0, i_result_wr_lo = 1'b0;
  logic i_burst_mode_enable = 1'b0, i_converter_enable = 1'b0, i_start = 1'b0, i_conv_done = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_result_wdata = 8'h00, o_sfr_rdata;
  logic [11:0] i_conv_data = 12'h000;
  logic o_twelve_bit_mode, o_conv_request, o_converter_powered, o_burst_busy, o_burst_done;
  logic [15:0] o_result_word;
  int n_errors = 0;
  int checked = 0;

  adc_accumulator_format u_adc_accumulator_format (.i_mclk, .i_reset, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
    .i_sfr_wdata, .o_sfr_rdata, .i_result_wr_hi, .i_result_wr_lo, .i_result_wdata, .i_burst_mode_enable,
    .i_converter_enable, .i_start, .i_conv_done, .i_conv_data, .o_twelve_bit_mode, .o_conv_request,
    .o_converter_powered, .o_burst_busy, .o_burst_done, .o_result_word);

  // ==========================================================================
  // Bus and converter helpers; outputs are read at the edge, before it updates them.
  // ==========================================================================
  always #50 i_mclk = ~i_mclk;

  task wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr <= a; i_sfr_wdata <= d; i_sfr_wr <= 1'b1;
    @(posedge i_mclk);
    i_sfr_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    i_sfr_addr <= a; i_sfr_rd <= 1'b1;
    @(posedge i_mclk);
    i_sfr_rd <= 1'b0;
    @(posedge i_mclk);
    `CHK(o_sfr_rdata, e)
  endtask

  // One conversion; the formatted word is settled when this returns.
  task conv(input logic [11:0] d);
    i_conv_data <= d; i_conv_done <= 1'b1;
    @(posedge i_mclk);
    i_conv_done <= 1'b0;
    repeat (2) @(posedge i_mclk);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task t_reg;
    rd(8'hba, 8'h00);
    `CHK(o_result_word, 16'h0000)
    wr(8'hba, 8'hd8);
    rd(8'hba, 8'h98);
    `CHK(o_twelve_bit_mode, 1'b1)
    wr(8'hbb, 8'hff);
    rd(8'hbb, 8'h00);
    rd(8'hba, 8'h98);
    wr(8'hba, 8'h00);
    rd(8'hba, 8'h00);
    `CHK(o_twelve_bit_mode, 1'b0)
    wr(8'hba, 8'hd8);
    @(posedge i_mclk);
    // A reset in mid-run must bring every field back to zero.
    i_reset <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    rd(8'hba, 8'h00);
    `CHK(o_twelve_bit_mode, 1'b0)
    $display("register test done");
  endtask

  // Replace, then clear and accumulate, then walk every format code.
  task t_format;
    conv(12'h123);
    conv(12'h456);
    `CHK(o_result_word, 16'h0456)
    wr(8'hba, 8'h40);
    i_result_wdata <= 8'h00; i_result_wr_hi <= 1'b1;
    @(posedge i_mclk);
    i_result_wr_hi <= 1'b0; i_result_wr_lo <= 1'b1;
    @(posedge i_mclk);
    i_result_wr_lo <= 1'b0;
    repeat (2) @(posedge i_mclk);
    `CHK(o_result_word, 16'h0000)
    conv(12'h100);
    conv(12'h100);
    `CHK(o_result_word, 16'h0200)
    for (int c = 1; c < 4; c++)
    begin
      wr(8'hba, 8'h40 | 8'(c << 3));
      repeat (3) @(posedge i_mclk);
      `CHK(o_result_word, 16'h0200 >> c)
    end
    wr(8'hba, 8'h60);
    repeat (3) @(posedge i_mclk);
    `CHK(o_result_word, 16'h8000)
    wr(8'hba, 8'he0);
    repeat (3) @(posedge i_mclk);
    `CHK(o_result_word, 16'h2000)
    $display("format test done");
  endtask

  // Every repeat code; power drops after each burst except the last, which runs with the converter enabled.
  task t_burst;
    int got;
    int n;
    i_burst_mode_enable <= 1'b1; i_conv_data <= 12'h001;
    for (int c = 0; c < 6; c++)
    begin
      n = (c == 0) ? 1 : (2 << c);
      got = 0;
      i_converter_enable <= (c == 5);
      wr(8'hba, 8'(c));
      i_start <= 1'b1;
      @(posedge i_mclk);
      i_start <= 1'b0;
      for (int k = 0; k < 400 && o_burst_done !== 1'b1; k++)
      begin
        @(posedge i_mclk);
        i_conv_done <= (o_conv_request === 1'b1);
        if (o_conv_request === 1'b1) got++;
      end
      `CHK(got, n)
      `CHK(o_burst_done, 1'b1)
      `CHK(o_burst_busy, 1'b0)
      `CHK(o_converter_powered, c == 5)
      repeat (2) @(posedge i_mclk);
      `CHK(o_result_word, 16'(n))
    end
    // Repeat field goes back to zero before burst mode is dropped.
    wr(8'hba, 8'h00);
    i_burst_mode_enable <= 1'b0;
    i_converter_enable <= 1'b0;
    $display("burst test done");
  endtask

  task wrap_up;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    repeat (6) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    t_reg;
    t_format;
    t_burst;
    wrap_up;
  end

  // Watchdog well past the few hundred cycles the tests need.
  initial
  begin
    #2000000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up;
  end
endmodule
